//--- framer_pkg.sv
package framer_pkg;

  // register select codes {high, mid, low}
  localparam logic [2:0] SEL_MASK      = 3'h0;
  localparam logic [2:0] SEL_TX_DATA   = 3'h2;
  localparam logic [2:0] SEL_CONTROL   = 3'h3;
  localparam logic [2:0] SEL_SYN_LOW   = 3'h4;
  localparam logic [2:0] SEL_SYN_HIGH  = 3'h5;
  localparam logic [2:0] SEL_RX_DATA   = 3'h6;
  localparam logic [2:0] SEL_STATUS    = 3'h7;

  // status and mask bit positions
  localparam int ST_RX_READY    = 0;
  localparam int ST_CKS_OK      = 1;
  localparam int ST_CKS_ERR     = 2;
  localparam int ST_TX_READY    = 3;
  localparam int ST_TX_IDLE     = 4;
  localparam int ST_TIMER       = 5;
  localparam int ST_CTRL_WORD   = 6;
  localparam int ST_TRAFFIC     = 7;

  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET    = 8'h00;

  // timing
  localparam int REF_HZ        = 4_032_000;
  localparam int BIT_DIV       = 3360;
  localparam int CLK_HZ        = 40_000_000;
  localparam int BIT_CYCLES    = CLK_HZ / (REF_HZ / BIT_DIV);
  localparam int TIMER_STEP    = 8;

  // framing
  localparam logic [15:0] control_frame_word = 16'hC4D7;
  localparam logic [15:0] traffic_frame_word = 16'h3B28;
  localparam logic [7:0]  PREAMBLE_BYTE      = 8'hAA;
  localparam int          PRE_MIN_BYTES      = 2;
  localparam int          CKS_DATA_BYTES     = 6;
  localparam int          FRAME_BYTES        = 8;
  localparam logic [15:0] CKS_POLY           = 16'h1021;

  typedef struct packed {
    logic [3:0] timer_code;
    logic       rx_framed;
    logic       rx_en;
    logic       tx_cks_en;
    logic       tx_en;
  } ctrl_s;

  typedef enum {TX_OFF, TX_PRE, TX_DATA, TX_CKS_HI, TX_CKS_LO, TX_HANG, TX_IDLE} tx_state_e;

endpackage : framer_pkg

//--- ffsk_radio_data_framer.sv
// Behaviour
// R1 - transmit and receive run together, independently, each at 1200 bit/s
// R2 - timer interrupts periodically, period 8 to 120 bit periods
// R3 - bit timing from 4.032 MHz reference (here ref_clk is taken as the 40 MHz CLK_HZ); clock divided by four driven out
// R4 - transmitter makes alternating preamble, at least 16 bits, ending on zero
// R5 - receiver detects control and traffic 16-bit frame words
// R6 - code words 64 bits long, bit 1 first; serial order kept both ways
// R7 - host supplies frame word as ordinary data; sent unchanged
// R8 - checksum on: 2-byte checksum sent after every 6 data bytes
// R9 - checksum off: no checksum bytes, data sent as continuous stream
// R10 - after last data, one hang bit, go idle, raise drained interrupt
// R11 - receiver bit-synchronises within 16 received bits
// R12 - no receive data before frame word; afterwards every bit in bytes
// R13 - framed checking compares checksum, reports interrupt and 16-bit syndrome
// R14 - receive mode: new frame word every 8 bytes, or continuous
// R15 - active-low interrupt request; cause shown in status register
// R16 - host forms the device strobe from address decode and read/write timing
// R17 - transmit output released to high impedance while transmitter disabled
// R18 - enable rise resyncs transmitter, starts preamble; whole preamble bytes until data
// R19 - bit period is reference divided by 3360 (here ref_clk divided by BIT_CYCLES, 33333 at CLK_HZ); checksum in replaceable submodule
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

module cks_engine #(
  parameter logic [15:0] POLY = 16'h1021
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // byte feed
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  din,
  // result
  output logic      [15:0] crc_q,
  output logic      [15:0] crc_nx
);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ b[i];
      r  = {r[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
    end
    return r;
  endfunction : crc_byte

  assign crc_nx = crc_byte(crc_q, din);

  always_ff @(posedge ref_clk) begin
    if (!reset_n || clr) begin
      crc_q <= 16'h0000;
    end else if (en) begin
      crc_q <= crc_nx;
    end
  end

endmodule : cks_engine

module ffsk_radio_data_framer #(
  parameter int BIT_CYCLES = framer_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // host register port
  input  wire logic        register_select_high,
  input  wire logic        register_select_mid,
  input  wire logic        register_select_low,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  // link
  output logic             tx_data_out,
  output logic             tx_data_oe,
  input  wire logic        rx_data_in,
  // system
  output logic             irq_n,
  output logic             clk_div4_out
);
  import framer_pkg::*;

  localparam int PW = $clog2(BIT_CYCLES);
  localparam logic [PW-1:0] PH_LAST = PW'(BIT_CYCLES - 1);
  localparam logic [PW-1:0] PH_MID  = PW'(BIT_CYCLES / 2);

  initial begin
    if (BIT_CYCLES < 4) $error("BIT_CYCLES too small");
  end

  logic [2:0]  sel;
  ctrl_s       ctrl_q;
  logic [7:0]  mask_q;
  logic [7:0]  status_q;
  logic [7:0]  ev_set;
  logic [7:0]  ev_clr;
  logic [15:0] syn_q;
  logic [7:0]  rx_data_q;
  logic [7:0]  rdata_q;
  logic        irq_n_q;
  logic [1:0]  div4_q;
  logic        div4_out_q;

  assign sel = {register_select_high, register_select_mid, register_select_low};

  // clock divided by four
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      div4_q     <= 2'h0;
      div4_out_q <= 1'b0;
    end else begin
      div4_q     <= div4_q + 2'h1; // R3
      div4_out_q <= div4_q[1];
    end
  end
  assign clk_div4_out = div4_out_q;

  // register writes
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_q <= CONTROL_RESET;
      mask_q <= MASK_RESET;
    end else if (wr_stb) begin
      if (sel == SEL_CONTROL) ctrl_q <= ctrl_s'(wdata);
      if (sel == SEL_MASK)    mask_q <= wdata;
    end
  end

  assign ev_clr = (wr_stb && sel == SEL_STATUS) ? wdata : 8'h00;

  // sticky status, set beats clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      status_q <= 8'h00;
    end else begin
      status_q <= (status_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|(((status_q & ~ev_clr) | ev_set) & mask_q); // R15
    end
  end
  assign irq_n = irq_n_q;

  // register reads, data in the following cycle only
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !rd_stb) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (sel)
        SEL_CONTROL:  rdata_q <= ctrl_q;
        SEL_MASK:     rdata_q <= mask_q;
        SEL_STATUS:   rdata_q <= status_q; // R15
        SEL_RX_DATA:  rdata_q <= rx_data_q;
        SEL_SYN_LOW:  rdata_q <= syn_q[7:0]; // R13
        SEL_SYN_HIGH: rdata_q <= syn_q[15:8]; // R13
        default:      rdata_q <= 8'h00;
      endcase
    end
  end
  assign rdata = rdata_q;

  // general timer
  logic [PW-1:0] tmr_ph_q;
  logic [6:0]    tmr_cnt_q;
  logic          tmr_ev;
  logic [6:0]    tmr_last;

  assign tmr_last = 7'(ctrl_q.timer_code * TIMER_STEP - 1);

  always_ff @(posedge ref_clk) begin
    if (!reset_n || ctrl_q.timer_code == 4'h0) begin
      tmr_ph_q  <= '0;
      tmr_cnt_q <= 7'h00;
      tmr_ev    <= 1'b0;
    end else begin
      tmr_ev <= 1'b0;
      if (tmr_ph_q == PH_LAST) begin
        tmr_ph_q <= '0;
        if (tmr_cnt_q >= tmr_last) begin
          tmr_cnt_q <= 7'h00;
          tmr_ev    <= 1'b1; // R2
        end else begin
          tmr_cnt_q <= tmr_cnt_q + 7'h01;
        end
      end else begin
        tmr_ph_q <= tmr_ph_q + PW'(1);
      end
    end
  end

  // transmit path
  tx_state_e   tx_st_q;
  logic [PW-1:0] tx_ph_q;
  logic        tx_en_d1_q;
  logic        cks_en_d1_q;
  logic [7:0]  tx_buf_q;
  logic        tx_full_q;
  logic [7:0]  tx_sh_q;
  logic [2:0]  tx_bits_q;
  logic [1:0]  pre_cnt_q;
  logic [2:0]  tx_dcnt_q;
  logic        tx_out_q;
  logic        tx_oe_q;
  logic        tx_tick;
  logic        tx_load;
  logic        tx_rdy_ev;
  logic        tx_idle_ev;
  logic        tx_crc_clr;
  logic [15:0] tx_crc;

  assign tx_tick = (tx_ph_q == PH_LAST);
  assign tx_load = tx_tick && tx_bits_q == 3'h0 && tx_full_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tx_en_d1_q  <= 1'b0;
      cks_en_d1_q <= 1'b0;
      tx_ph_q     <= '0;
    end else begin
      tx_en_d1_q  <= ctrl_q.tx_en;
      cks_en_d1_q <= ctrl_q.tx_cks_en;
      if (ctrl_q.tx_en && !tx_en_d1_q) tx_ph_q <= '0; // R18
      else if (tx_tick) tx_ph_q <= '0; // R1
      else tx_ph_q <= tx_ph_q + PW'(1);
    end
  end

  // transmit buffer
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !ctrl_q.tx_en) begin
      tx_full_q <= 1'b0;
      tx_buf_q  <= 8'h00;
    end else if (wr_stb && sel == SEL_TX_DATA) begin
      tx_full_q <= 1'b1;
      tx_buf_q  <= wdata; // R7
    end else if (tx_load && (tx_st_q != TX_PRE || pre_cnt_q == 2'(PRE_MIN_BYTES - 1))
                 && !(tx_st_q == TX_DATA && ctrl_q.tx_cks_en && tx_dcnt_q == 3'(CKS_DATA_BYTES))
                 && tx_st_q != TX_CKS_HI && tx_st_q != TX_HANG) begin
      tx_full_q <= 1'b0;
    end
  end

  assign tx_crc_clr = !ctrl_q.tx_cks_en || (ctrl_q.tx_cks_en && !cks_en_d1_q);

  // underrun aborts a partial checksum
  cks_engine #(.POLY(CKS_POLY)) u_tx_cks ( // R19
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clr     (tx_crc_clr || tx_st_q == TX_HANG || (tx_st_q == TX_CKS_LO && tx_tick && tx_bits_q == 3'h0)),
    .en      (tx_rdy_ev && tx_dcnt_q <= 3'(CKS_DATA_BYTES)),
    .din     (tx_buf_q),
    .crc_q   (tx_crc),
    .crc_nx  ()
  );

  // serialiser, msb (bit 1) first
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !ctrl_q.tx_en) begin
      tx_st_q    <= TX_OFF;
      tx_sh_q    <= 8'h00;
      tx_bits_q  <= 3'h0;
      pre_cnt_q  <= 2'h0;
      tx_dcnt_q  <= 3'h0;
      tx_out_q   <= 1'b0;
      tx_oe_q    <= 1'b0; // R17
      tx_rdy_ev  <= 1'b0;
      tx_idle_ev <= 1'b0;
    end else begin
      tx_oe_q    <= 1'b1;
      tx_rdy_ev  <= 1'b0;
      tx_idle_ev <= 1'b0;
      if (ctrl_q.tx_cks_en && !cks_en_d1_q) tx_dcnt_q <= 3'h0; // R8
      if (tx_st_q == TX_OFF) begin
        tx_st_q   <= TX_PRE; // R18
        tx_bits_q <= 3'h7;
        pre_cnt_q <= 2'h0;
        tx_sh_q   <= {PREAMBLE_BYTE[6:0], 1'b0};
        tx_out_q  <= PREAMBLE_BYTE[7];
      end else if (tx_tick && tx_bits_q != 3'h0) begin
        tx_out_q  <= tx_sh_q[7]; // R6
        tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
        tx_bits_q <= tx_bits_q - 3'h1;
      end else if (tx_tick) begin
        tx_bits_q <= 3'h7;
        unique case (tx_st_q)
          TX_PRE: begin
            if (tx_full_q && pre_cnt_q == 2'(PRE_MIN_BYTES - 1)) begin // R4
              tx_st_q   <= TX_DATA;
              tx_out_q  <= tx_buf_q[7];
              tx_sh_q   <= {tx_buf_q[6:0], 1'b0};
              tx_rdy_ev <= 1'b1;
              tx_dcnt_q <= tx_dcnt_q + 3'h1;
            end else begin
              if (pre_cnt_q != 2'(PRE_MIN_BYTES - 1)) pre_cnt_q <= pre_cnt_q + 2'h1;
              tx_out_q <= PREAMBLE_BYTE[7]; // R18
              tx_sh_q  <= {PREAMBLE_BYTE[6:0], 1'b0};
            end
          end
          TX_DATA, TX_CKS_LO, TX_IDLE: begin
            if (tx_st_q == TX_DATA && ctrl_q.tx_cks_en && tx_dcnt_q == 3'(CKS_DATA_BYTES)) begin
              tx_st_q  <= TX_CKS_HI; // R8
              tx_out_q <= tx_crc[15];
              tx_sh_q  <= {tx_crc[14:8], 1'b0};
            end else if (tx_full_q) begin
              tx_st_q   <= TX_DATA; // R9
              tx_out_q  <= tx_buf_q[7];
              tx_sh_q   <= {tx_buf_q[6:0], 1'b0};
              tx_rdy_ev <= 1'b1;
              tx_dcnt_q <= (tx_st_q == TX_CKS_LO ? 3'h0 : tx_dcnt_q) + 3'h1;
            end else if (tx_st_q == TX_IDLE) begin
              tx_bits_q <= 3'h0;
            end else begin
              tx_st_q   <= TX_HANG; // R10
              tx_bits_q <= 3'h0;
              tx_dcnt_q <= 3'h0;
            end
          end
          TX_CKS_HI: begin
            tx_st_q  <= TX_CKS_LO;
            tx_out_q <= tx_crc[7];
            tx_sh_q  <= {tx_crc[6:0], 1'b0};
          end
          TX_HANG: begin
            tx_st_q    <= TX_IDLE; // R10
            tx_bits_q  <= 3'h0;
            tx_idle_ev <= 1'b1;
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end
  assign tx_data_out = tx_out_q;
  assign tx_data_oe  = tx_oe_q;

  // receive path
  logic          rx_s1_q;
  logic          rx_s2_q;
  logic          rx_s3_q;
  logic [PW-1:0] rx_ph_q;
  logic          rx_smp;
  logic [15:0]   rx_hist_q;
  logic [15:0]   rx_hist_nx;
  logic          rx_lock_q;
  logic [2:0]    rx_bits_q;
  logic [2:0]    rx_bytes_q;
  logic [7:0]    rx_byte_nx;
  logic          rx_byte_done;
  logic          rx_frame_end;
  logic [15:0]   rx_crc_nx;
  logic [7:0]    rx_ev;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
    end else begin
      rx_s1_q <= rx_data_in;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // phase realigned on every transition
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !ctrl_q.rx_en) begin
      rx_ph_q <= '0;
    end else if (rx_s2_q != rx_s3_q || rx_ph_q == PH_LAST) begin
      rx_ph_q <= '0; // R11
    end else begin
      rx_ph_q <= rx_ph_q + PW'(1);
    end
  end

  assign rx_smp       = ctrl_q.rx_en && rx_ph_q == PH_MID;
  assign rx_hist_nx   = {rx_hist_q[14:0], rx_s3_q};
  assign rx_byte_nx   = rx_hist_nx[7:0];
  assign rx_byte_done = rx_smp && rx_lock_q && rx_bits_q == 3'h7;
  assign rx_frame_end = rx_byte_done && ctrl_q.rx_framed && rx_bytes_q == 3'(FRAME_BYTES - 1);

  cks_engine #(.POLY(CKS_POLY)) u_rx_cks (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clr     (!rx_lock_q || rx_frame_end),
    .en      (rx_byte_done),
    .din     (rx_byte_nx),
    .crc_q   (),
    .crc_nx  (rx_crc_nx)
  );

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !ctrl_q.rx_en) begin
      rx_hist_q  <= 16'h0000;
      rx_lock_q  <= 1'b0;
      rx_bits_q  <= 3'h0;
      rx_bytes_q <= 3'h0;
      rx_ev      <= 8'h00;
    end else begin
      rx_ev <= 8'h00;
      if (rx_smp) begin
        rx_hist_q <= rx_hist_nx;
        if (!rx_lock_q) begin
          rx_bits_q  <= 3'h0;
          rx_bytes_q <= 3'h0;
          if (rx_hist_nx == control_frame_word) begin
            rx_lock_q           <= 1'b1; // R5
            rx_ev[ST_CTRL_WORD] <= 1'b1;
          end
          if (rx_hist_nx == traffic_frame_word) begin
            rx_lock_q          <= 1'b1; // R5
            rx_ev[ST_TRAFFIC]  <= 1'b1;
          end
        end else begin
          rx_bits_q <= rx_bits_q + 3'h1;
          if (rx_byte_done) begin
            rx_ev[ST_RX_READY] <= 1'b1; // R12
            rx_bytes_q         <= rx_bytes_q + 3'h1;
            if (rx_frame_end) begin
              rx_lock_q  <= 1'b0; // R14
              rx_bytes_q <= 3'h0;
              rx_ev[ST_CKS_OK]  <= (rx_crc_nx == 16'h0000); // R13
              rx_ev[ST_CKS_ERR] <= (rx_crc_nx != 16'h0000); // R13
            end
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rx_data_q <= 8'h00;
      syn_q     <= 16'h0000;
    end else begin
      if (rx_byte_done) rx_data_q <= rx_byte_nx; // R12
      if (rx_frame_end) syn_q <= rx_crc_nx; // R13
    end
  end

  always_comb begin
    ev_set              = rx_ev;
    ev_set[ST_TX_READY] = tx_rdy_ev;
    ev_set[ST_TX_IDLE]  = tx_idle_ev;
    ev_set[ST_TIMER]    = tmr_ev;
  end

endmodule : ffsk_radio_data_framer

//--- framer_checker_properties.sv
`timescale 1ns/1ps
module framer_checker #(
  parameter int BIT_CYCLES = 40
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // host port
  input wire logic       register_select_high,
  input wire logic       register_select_mid,
  input wire logic       register_select_low,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  // link and system
  input wire logic       tx_data_out,
  input wire logic       tx_data_oe,
  input wire logic       irq_n,
  input wire logic       clk_div4_out
);
  import framer_pkg::*;
  logic [2:0] sel;
  logic       last_q;
  logic       oe_q;
  int         run_q;
  assign sel = {register_select_high, register_select_mid, register_select_low};
  // cycles since the line last moved
  always_ff @(posedge ref_clk) begin
    last_q <= tx_data_out;
    oe_q   <= tx_data_oe;
    run_q  <= (!tx_data_oe || tx_data_out != last_q) ? 1 : run_q + 1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  property p_div4_rise;
    $rose(clk_div4_out) |=> clk_div4_out ##1 !clk_div4_out ##1 !clk_div4_out ##1 clk_div4_out;
  endproperty
  a_div4_rise: assert property (p_div4_rise) else $error("div4 high phase wrong");
  property p_div4_fall;
    $fell(clk_div4_out) |=> !clk_div4_out ##1 clk_div4_out;
  endproperty
  a_div4_fall: assert property (p_div4_fall) else $error("div4 low phase wrong");
  property p_bit_period;
    tx_data_oe && oe_q && tx_data_out != last_q |-> (run_q % BIT_CYCLES) == 0;
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("tx edge off the bit grid");
  property p_rdata_quiet;
    !rd_stb |=> rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data without strobe");
  property p_mask_off;
    wr_stb && sel == SEL_MASK && wdata == 8'h00 ##1 !wr_stb |=> irq_n;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
  property p_oe_on;
    wr_stb && sel == SEL_CONTROL && wdata[0] ##1 !wr_stb |-> ##[0:1] tx_data_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("tx not driving after enable");
  property p_oe_off;
    wr_stb && sel == SEL_CONTROL && !wdata[0] ##1 !wr_stb |-> ##[0:1] !tx_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("tx driving while disabled");
  property p_preamble_first;
    $rose(tx_data_oe) |-> ##[0:1] tx_data_out [*8];
  endproperty
  a_preamble_first: assert property (p_preamble_first) else $error("preamble not led by one");
endmodule : framer_checker

bind ffsk_radio_data_framer framer_checker #(.BIT_CYCLES(BIT_CYCLES)) framer_checker_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .register_select_high(register_select_high),
  .register_select_mid(register_select_mid), .register_select_low(register_select_low),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tx_data_out(tx_data_out),
  .tx_data_oe(tx_data_oe), .irq_n(irq_n), .clk_div4_out(clk_div4_out));

//--- link_peer.sv
`timescale 1ns/1ps
module link_peer #(
  parameter int BIT_CYCLES = 40
) (
  // clock
  input  wire logic        ref_clk,
  // far end of the link
  input  wire logic        tx_data_out,
  input  wire logic        tx_data_oe,
  output logic             rx_data_in,
  // bench control and capture
  input  wire logic        corrupt,
  output logic      [15:0] pre_q
);
  int ph_q = 0;
  int cnt_q = 0;
  // loop back; released line shows the opposite of the idle output level
  always_ff @(posedge ref_clk) begin
    if (tx_data_oe) begin
      rx_data_in <= tx_data_out ^ corrupt;
    end else begin
      rx_data_in <= ~tx_data_out;
    end
  end
  // first 16 line bits after enable, sampled mid-bit
  always_ff @(posedge ref_clk) begin
    if (!tx_data_oe) begin
      ph_q  <= 0;
      cnt_q <= 0;
    end else begin
      ph_q <= (ph_q == BIT_CYCLES - 1) ? 0 : ph_q + 1;
      if (ph_q == BIT_CYCLES / 2 && cnt_q < 16) begin
        pre_q <= {pre_q[14:0], tx_data_out};
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule : link_peer

//--- ffsk_radio_data_framer_tb_top.sv
`timescale 1ns/1ps
module ffsk_radio_data_framer_tb_top;
  import framer_pkg::*;
  localparam int BC = 40;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  sel = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        corrupt = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  st;
  logic [7:0]  rv;
  logic [7:0]  hi;
  logic [7:0]  txb [8];
  logic [15:0] pre_q;
  logic        tx_data_out;
  logic        tx_data_oe;
  logic        rx_data_in;
  logic        irq_n;
  logic        clk_div4_out;
  int          num_errors = 0;
  int          num_checks = 0;
  int          seed = 11;
  int          n;
  always #12.5 ref_clk = ~ref_clk;

  ffsk_radio_data_framer #(.BIT_CYCLES(BC)) ffsk_radio_data_framer_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .register_select_high(sel[2]),
    .register_select_mid(sel[1]), .register_select_low(sel[0]), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tx_data_out(tx_data_out),
    .tx_data_oe(tx_data_oe), .rx_data_in(rx_data_in), .irq_n(irq_n), .clk_div4_out(clk_div4_out));
  link_peer #(.BIT_CYCLES(BC)) link_peer_i (
    .ref_clk(ref_clk), .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe),
    .rx_data_in(rx_data_in), .corrupt(corrupt), .pre_q(pre_q));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("mismatches %0d of %0d checks", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    sel <= s;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    sel <= s;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
    @(posedge ref_clk);
  endtask : rd

  task automatic wait_irq(input logic lvl);
    for (n = 0; n < 6000 && irq_n !== lvl; n++) begin
      @(posedge ref_clk);
    end
    if (n == 6000) begin
      num_errors++;
      final_report();
    end
  endtask : wait_irq

  // frame word and six data bytes out, looped back into the receiver
  task automatic run_frame(input logic [15:0] fw, input logic bad);
    int got;
    int k;
    got = 0;
    k = 1;
    txb[0] = fw[15:8];
    txb[1] = fw[7:0];
    for (int i = 2; i < 8; i++) begin
      txb[i] = 8'($random(seed));
    end
    wr(SEL_STATUS, 8'hFF);
    wr(SEL_CONTROL, 8'h0D);
    wr(SEL_TX_DATA, txb[0]);
    for (int j = 0; j < 4000 && got < 8; j++) begin
      rd(SEL_STATUS, st);
      if (st[ST_RX_READY] === 1'b1) begin
        wr(SEL_STATUS, 8'h01);
        rd(SEL_RX_DATA, rv);
        if (!bad && got < 6) check(16'(rv), 16'(txb[got + 2]));
        got++;
      end
      if (st[ST_TX_READY] === 1'b1 && k < 8) begin
        wr(SEL_STATUS, 8'h08);
        if (k == 2) wr(SEL_CONTROL, 8'h0F);
        corrupt <= bad && k == 5;
        wr(SEL_TX_DATA, txb[k]);
        k++;
      end
    end
    if (got < 8) begin
      num_errors++;
      final_report();
    end
    check(pre_q, 16'hAAAA);
    rd(SEL_STATUS, st);
    check(16'({st[ST_CKS_OK], st[ST_CKS_ERR]}), bad ? 16'h1 : 16'h2);
    check(16'(fw == control_frame_word ? st[ST_CTRL_WORD] : st[ST_TRAFFIC]), 16'h1);
    rd(SEL_SYN_HIGH, hi);
    rd(SEL_SYN_LOW, rv);
    check(16'({hi, rv} != 16'h0000), 16'(bad));
    wr(SEL_MASK, 8'h10);
    wait_irq(1'b0);
    rd(SEL_STATUS, st);
    check(16'(st[ST_TX_IDLE]), 16'h1);
    wr(SEL_MASK, 8'h00);
    @(posedge ref_clk);
    check(16'(irq_n), 16'h1);
    wr(SEL_CONTROL, 8'h00);
    @(posedge ref_clk);
    check(16'(tx_data_oe), 16'h0);
  endtask : run_frame

  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check(16'({irq_n, tx_data_oe}), 16'h2);
    rd(SEL_CONTROL, rv);
    check(16'(rv), 16'(CONTROL_RESET));
    rd(SEL_MASK, rv);
    check(16'(rv), 16'(MASK_RESET));
    wr(3'h1, 8'hFF);
    rd(3'h1, rv);
    check(16'(rv), 16'h0000);
    hi = 8'($random(seed));
    wr(SEL_MASK, hi);
    rd(SEL_MASK, rv);
    check(16'(rv), 16'(hi));
    wr(SEL_MASK, 8'h20);
    foreach (txb[i]) begin
      if (i == 1 || i == 7) begin
        wr(SEL_STATUS, 8'hFF);
        wr(SEL_CONTROL, 8'(i * 16 + 16));
        wait_irq(1'b0);
        check(16'(n > (i + 1) * 8 * BC - 6 && n < (i + 1) * 8 * BC + 4), 16'h1);
      end
    end
    wr(SEL_MASK, 8'h00);
    wr(SEL_STATUS, 8'hFF);
    repeat (16 * 8 * BC) @(posedge ref_clk);
    rd(SEL_STATUS, st);
    check(16'({irq_n, st[ST_TIMER]}), 16'h3);
    wr(SEL_MASK, 8'h20);
    @(posedge ref_clk);
    check(16'(irq_n), 16'h0);
    wr(SEL_CONTROL, 8'h00);
    wr(SEL_STATUS, 8'h20);
    @(posedge ref_clk);
    check(16'(irq_n), 16'h1);
    wr(SEL_MASK, 8'h00);
    run_frame(control_frame_word, 1'b0);
    run_frame(traffic_frame_word, 1'b1);
    final_report();
  end
endmodule : ffsk_radio_data_framer_tb_top
